// >>> verilog/eeh_host.sv
// Two-wire EEPROM host controller: AHB-Lite registers and bus-primitive engine
module eeh_host
  import eeh_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE_CODE = 4'h3  // Arbitrary neutral value, set by the integrator
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_LOW     = 7'b0000010,
    S_HIGH    = 7'b0000100,
    S_STA_HI  = 7'b0001000,
    S_STA_HLD = 7'b0010000,
    S_STO_HI  = 7'b0100000,
    S_STO_BUF = 7'b1000000
  } eeh_state_t;

  eeh_state_t  st_q, st_d;
  eeh_op_t     op_q, op_d;
  logic [8:0]  cnt_q, cnt_d;
  logic [3:0]  bit_q, bit_d;
  logic [8:0]  sh_q, sh_d;
  logic [8:0]  rx_q, rx_d;
  logic        ack_q, ack_d;
  logic        scl_q, scl_d;
  logic        oe_q, oe_d;
  logic        nack_q, nack_d;
  logic        found_q, found_d;
  logic [7:0]  rxd_q, rxd_d;
  logic        sda_m_q, sda_s_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic [18:0] cfg_q;
  logic [7:0]  txd_q;

  wire logic        ahb_go;
  wire logic        wr_ctrl;
  wire logic        wr_cfg;
  wire logic        wr_txd;
  wire eeh_cmd_t    cmd;
  wire logic        go;
  wire logic        busy;
  wire logic        tdone;
  wire logic [31:0] rd_mux;
  wire logic [7:0]  dev_word;
  wire logic [2:0]  page;

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY
  // ----------------------------------------------------------------
  assign ahb_go  = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_q && (wr_addr_q == CTRL_OFF);
  assign wr_cfg  = wr_pend_q && (wr_addr_q == CFG_OFF);
  assign wr_txd  = wr_pend_q && (wr_addr_q == TXD_OFF);
  assign cmd     = eeh_cmd_t'(hwdata[4:0]);
  assign go      = wr_ctrl && (st_q == S_IDLE) && (cmd.op != OP_NONE);
  assign busy    = (st_q != S_IDLE) || go;

  // Read decode; unmapped offsets read as zero
  assign rd_mux = (haddr[7:0] == CFG_OFF)  ? {13'h0000, cfg_q} :
                  (haddr[7:0] == TXD_OFF)  ? {24'h000000, txd_q} :
                  (haddr[7:0] == STAT_OFF) ? {16'h0000, rxd_q, 5'h00,
                                              found_q, nack_q, busy} :
                  32'h00000000;

  // Address phase capture and read data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= ahb_go && hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata_q  <= (ahb_go && !hwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Software registers written in the data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= CFG_RST;
      txd_q <= TXD_RST;
    end else begin
      if (wr_cfg) cfg_q <= hwdata[18:0];
      if (wr_txd) txd_q <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Device address word
  // ----------------------------------------------------------------
  assign page = cfg_q[CFG_WADDR_LSB+8 +: 3];

  // Select bits give way to page bits as the memory grows
  function automatic logic [2:0] sel_field(input logic [2:0] sz, input logic [2:0] sel,
                                           input logic [2:0] pg);
    if (sz == SZ_4K)       return {sel[2:1], pg[0]};
    else if (sz == SZ_8K)  return {sel[2], pg[1:0]};
    else if (sz == SZ_16K) return pg;
    else                   return sel;
  endfunction

  // Type code, select or page bits, direction bit last
  assign dev_word = {DEV_TYPE_CODE,
                     sel_field(cfg_q[CFG_SIZE_LSB +: 3], cfg_q[CFG_SEL_LSB +: 3], page),
                     cmd.rw};

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  assign tdone = (cnt_q == 9'h000);

  // Next state of the primitive engine
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    cnt_d   = tdone ? cnt_q : cnt_q - 9'h001;
    bit_d   = bit_q;
    sh_d    = sh_q;
    rx_d    = rx_q;
    ack_d   = ack_q;
    scl_d   = scl_q;
    oe_d    = oe_q;
    nack_d  = nack_q;
    found_d = found_q;
    rxd_d   = rxd_q;
    case (st_q)
      S_IDLE: begin
        if (go) begin
          st_d  = S_LOW;
          op_d  = cmd.op;
          ack_d = cmd.ack;
          cnt_d = LOW_CYC;
          bit_d = 4'h0;
          scl_d = 1'b0;
          if (cmd.op == OP_STOP) sh_d = 9'h000;
          else if (cmd.op == OP_DEV) sh_d = {dev_word, 1'b1};
          else if (cmd.op == OP_WADDR) sh_d = {cfg_q[CFG_WADDR_LSB +: 8], 1'b1};
          else if (cmd.op == OP_WRITE) sh_d = {txd_q, 1'b1};
          else if (cmd.op == OP_READ) sh_d = {8'hff, ~cmd.ack};
          else sh_d = 9'h1ff;
          if (cmd.op == OP_RECOV) found_d = 1'b0;
        end
      end
      S_LOW: begin
        oe_d = ~sh_q[8];
        if (tdone) begin
          scl_d = 1'b1;
          if (op_q == OP_START) begin
            st_d  = S_STA_HI;
            cnt_d = SU_STA_CYC;
          end else if (op_q == OP_STOP) begin
            st_d  = S_STO_HI;
            cnt_d = SU_STO_CYC;
          end else begin
            st_d  = S_HIGH;
            cnt_d = HIGH_CYC;
          end
        end
      end
      S_HIGH: begin
        if (tdone) begin
          scl_d = 1'b0;
          rx_d  = {rx_q[7:0], sda_s_q};
          sh_d  = {sh_q[7:0], 1'b1};
          cnt_d = LOW_CYC;
          if (op_q == OP_RECOV && (sda_s_q || bit_q == 4'h8)) begin
            st_d    = S_LOW;
            op_d    = OP_START;
            sh_d    = 9'h1ff;
            found_d = sda_s_q;
          end else if (bit_q == 4'h8) begin
            st_d   = S_IDLE;
            nack_d = sda_s_q;
            rxd_d  = rx_q[7:0];
          end else begin
            st_d  = S_LOW;
            bit_d = bit_q + 4'h1;
          end
        end
      end
      S_STA_HI: begin
        if (tdone) begin
          st_d  = S_STA_HLD;
          oe_d  = 1'b1;
          cnt_d = HD_STA_CYC;
        end
      end
      S_STA_HLD: begin
        if (tdone) begin
          st_d  = S_IDLE;
          scl_d = 1'b0;
        end
      end
      S_STO_HI: begin
        if (tdone) begin
          st_d  = S_STO_BUF;
          oe_d  = 1'b0;
          cnt_d = BUF_CYC;
        end
      end
      S_STO_BUF: begin
        if (tdone) st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  // Engine registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q    <= S_IDLE;
      op_q    <= OP_NONE;
      cnt_q   <= 9'h000;
      bit_q   <= 4'h0;
      sh_q    <= 9'h1ff;
      rx_q    <= 9'h000;
      ack_q   <= 1'b0;
      scl_q   <= 1'b1;
      oe_q    <= 1'b0;
      nack_q  <= 1'b0;
      found_q <= 1'b0;
      rxd_q   <= 8'h00;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      rx_q    <= rx_d;
      ack_q   <= ack_d;
      scl_q   <= scl_d;
      oe_q    <= oe_d;
      nack_q  <= nack_d;
      found_q <= found_d;
      rxd_q   <= rxd_d;
    end
  end

  // Outputs straight from flip-flops or tied to constants
  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl       = scl_q;
  assign sda_o     = 1'b0;
  assign sda_oe    = oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_sta_hi;
    (st_q == S_STA_HI) && tdone;
  endsequence

  sequence s_sta_edge;
    scl_q && oe_q && (st_q == S_STA_HLD);
  endsequence

  sda_stable_a: assert property ((st_q == S_HIGH) && $past(st_q == S_HIGH)
    |-> $stable(oe_q)) else $error("SDA moved while SCL high in a data bit");
  start_edge_a: assert property (s_sta_hi |=> s_sta_edge)
    else $error("Start did not pull SDA low with SCL high");
  stop_edge_a: assert property ($fell(oe_q) && scl_q |-> st_q == S_STO_BUF)
    else $error("SDA released with SCL high outside a stop");
  byte_len_a: assert property ((st_q == S_HIGH) && tdone && (bit_q == 4'h8)
    && (op_q != OP_RECOV) |=> (st_q == S_IDLE) && !scl_q)
    else $error("Byte did not end after the ninth clock");
  dev_type_a: assert property (go && (cmd.op == OP_DEV)
    |=> sh_q[8:5] == DEV_TYPE_CODE && sh_q[1] == $past(hwdata[4]))
    else $error("Device word lacks type code or direction");
  page_bits_a: assert property (go && (cmd.op == OP_DEV)
    && (cfg_q[CFG_SIZE_LSB +: 3] == SZ_16K) |=> sh_q[4:2] == page)
    else $error("Page bits missing from device word");
  read_ack_a: assert property ((st_q == S_HIGH) && (op_q == OP_READ)
    && (bit_q == 4'h8) |-> oe_q == ack_q)
    else $error("Host acknowledge after read byte is wrong");
  recov_max_a: assert property ((op_q == OP_RECOV) |-> bit_q <= 4'h8)
    else $error("Recovery ran past nine clocks");
  scl_low_a: assert property ($fell(scl_q) |=> !scl_q [*8])
    else $error("SCL low phase too short");

endmodule // eeh_host

// >>> verilog/eeh_pkg.sv
// Package: register map, field layout, commands and bus timing of the EEPROM host controller
package eeh_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the AHB-Lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF  = 8'h04;
  localparam logic [7:0] TXD_OFF  = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0c;

  // Field positions
  localparam int CFG_SEL_LSB   = 0;
  localparam int CFG_SIZE_LSB  = 3;
  localparam int CFG_WADDR_LSB = 8;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_NACK     = 1;
  localparam int STAT_FOUND    = 2;
  localparam int STAT_RX_LSB   = 8;

  // Reset values
  localparam logic [18:0] CFG_RST = 19'h00000;
  localparam logic [7:0]  TXD_RST = 8'h00;

  // Memory size codes held in the configuration register
  localparam logic [2:0] SZ_1K  = 3'h0;
  localparam logic [2:0] SZ_2K  = 3'h1;
  localparam logic [2:0] SZ_4K  = 3'h2;
  localparam logic [2:0] SZ_8K  = 3'h3;
  localparam logic [2:0] SZ_16K = 3'h4;

  // Bus primitives that software orders through the control register
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_START = 3'h1,
    OP_STOP  = 3'h2,
    OP_DEV   = 3'h3,
    OP_WADDR = 3'h4,
    OP_WRITE = 3'h5,
    OP_READ  = 3'h6,
    OP_RECOV = 3'h7
  } eeh_op_t;

  // Control word as written by software
  typedef struct packed {
    logic    rw;
    logic    ack;
    eeh_op_t op;
  } eeh_cmd_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_SCL_NS      = 2500;
  localparam int T_LOW_NS      = 1200;
  localparam int T_SU_STA_NS   = 600;
  localparam int T_HD_STA_NS   = 600;
  localparam int T_SU_STO_NS   = 600;
  localparam int T_BUF_NS      = 1200;

  // Least time in whole clock cycles, never below one
  function automatic logic [8:0] cyc_ceil(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 9'h001 : c[8:0];
  endfunction

  localparam logic [8:0] LOW_CYC    = cyc_ceil(T_LOW_NS);
  localparam logic [8:0] HIGH_CYC   = cyc_ceil(T_SCL_NS - T_LOW_NS);
  localparam logic [8:0] SU_STA_CYC = cyc_ceil(T_SU_STA_NS);
  localparam logic [8:0] HD_STA_CYC = cyc_ceil(T_HD_STA_NS);
  localparam logic [8:0] SU_STO_CYC = cyc_ceil(T_SU_STO_NS);
  localparam logic [8:0] BUF_CYC    = cyc_ceil(T_BUF_NS);

endpackage

// >>> tb/eeh_mem_model.sv
// Behavioural two-wire memory device, 2K organisation, on the far side of the host
module eeh_mem_model #(
  parameter logic [3:0] TYPE_CODE = 4'h3,  // Arbitrary value, same as the host default
  parameter int         PROG_NS   = 25000  // Shortened program cycle: the first poll falls inside it
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic select_pin_high,
  input  wire logic select_pin_mid,
  input  wire logic select_pin_low,
  input  wire logic write_protect,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [256];
  logic [7:0] sr, addr;
  logic [7:0] pa [$];
  logic [7:0] pd [$];
  int         bitn, phase;
  logic       tx, busy;
  wire  [2:0] sel_pins = {select_pin_high, select_pin_mid, select_pin_low};

  // Known contents, standby at power-up
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i + 8'h7e);
    end
    {sr, addr, tx, busy, sda_oe} = '0;
    bitn = 0;
    phase = 0;
  end

  // Start: data falls while the clock is high; ignored while programming
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      tx = 1'b0;
      sda_oe = 1'b0;
      pa.delete();
      pd.delete();
      phase = busy ? 0 : 1;
    end
  end

  // Stop: commits a write and starts the program cycle, then standby
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      if (pa.size() > 0) begin
        foreach (pa[i]) mem[pa[i]] = pd[i];
        busy = 1'b1;
        busy <= #(PROG_NS) 1'b0;
      end
      phase = 0;
      tx = 1'b0;
    end
  end

  // Bits are taken on the rising clock edge, most significant first
  always @(posedge scl) begin
    if (phase != 0) begin
      if (bitn < 8) begin
        sr = {sr[6:0], sda};
        bitn++;
      end else if (bitn == 8) begin
        if (tx) begin
          addr = addr + 8'h1;
          if (sda) phase = 0;
        end
        bitn = 9;
      end
    end
  end

  // Outgoing bits and acknowledges change on the falling clock edge, open drain
  always @(negedge scl) begin
    if (phase != 0) begin
      if (bitn == 9) begin
        bitn = 0;
        sda_oe = 1'b0;
        tx = (phase == 4);
      end
      if (tx && bitn < 8) sda_oe = ~mem[addr][7 - bitn];
      else if (tx) sda_oe = 1'b0;
      else if (bitn == 8) take_word();
    end
  end

  // Acknowledge a received word and act on it
  task automatic take_word();
    // A foreign device word is never acknowledged, not even for a moment
    if (phase == 1 && (sr[7:4] != TYPE_CODE || sr[3:1] != sel_pins)) begin
      phase = 0;
      return;
    end
    sda_oe = 1'b1;
    if (phase == 1) begin
      phase = sr[0] ? 4 : 2;
    end else if (phase == 2) begin
      addr = sr;
      phase = 3;
    end else if (!write_protect) begin
      pa.push_back(addr);
      pd.push_back(sr);
      addr = {addr[7:3], addr[2:0] + 3'h1};
    end
  endtask
endmodule  // eeh_mem_model

// >>> tb/tb_eeh_host.sv
// Testbench of the EEPROM host controller against the behavioural memory device
module tb_eeh_host
  import eeh_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rstn, hsel, hwrite, wp;
  logic [31:0] haddr, hwdata, hrdata, st, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, scl, sda_o, sda_oe, dev_oe;
  logic [7:0]  pg [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  wire         sda_w = ~(sda_oe | dev_oe);  // Pull-up unless a party pulls low
  int          failures, n_compared, tries;

  eeh_host DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe));

  eeh_mem_model MEM (.scl(scl), .sda(sda_w), .select_pin_high(1'b1), .select_pin_mid(1'b0),
    .select_pin_low(1'b1), .write_protect(wp), .sda_oe(dev_oe));

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #550000;  // About 110k clocks; the full sequence needs about 95k
    failures++;
    summarize();
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic nk(input string what, input logic exp);
    chk(what, {31'h0, exp}, {31'h0, st[STAT_NACK]});
  endtask

  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One single AHB-Lite transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Order one bus primitive and wait until the engine is idle
  task automatic op(input eeh_op_t o, input logic rw = 1'b0, input logic ak = 1'b0);
    eeh_cmd_t c;
    c = '{rw: rw, ack: ak, op: o};
    ahb(1'b1, CTRL_OFF, {27'h0, c}, d);
    repeat (3000) begin
      ahb(1'b0, STAT_OFF, 32'h0, st);
      if (st[STAT_BUSY] === 1'b0) break;
    end
    chk("engine idle", 32'h0, {31'h0, st[STAT_BUSY]});  // Limit ran out if still busy
  endtask

  task automatic poll(input logic rw);
    tries = 0;
    do begin
      op(OP_START);
      op(OP_DEV, rw);
      tries++;
    end while (st[STAT_NACK] !== 1'b0 && tries < 4);
  endtask

  task automatic cfg(input logic [2:0] sz, input logic [2:0] sel, input logic [10:0] wa);
    ahb(1'b1, CFG_OFF, {13'h0, wa, 2'h0, sz, sel}, d);
  endtask

  // Main sequence
  initial begin
    {hsel, hwrite, wp} = 3'b000;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    failures = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("scl idle", 32'h1, {31'h0, scl & sda_w});
    ahb(1'b0, CFG_OFF, 32'h0, d);
    chk("cfg reset", {13'h0, CFG_RST}, d);
    ahb(1'b1, TXD_OFF, 32'hffffffff, d);
    ahb(1'b0, TXD_OFF, 32'h0, d);
    chk("txd field", 32'hff, d);
    ahb(1'b1, 8'h10, 32'h5a5a5a5a, d);
    ahb(1'b0, 8'h10, 32'h0, d);
    chk("unmapped", 32'h0, d);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("sda data", 32'h0, {31'h0, sda_o});
    // Byte write
    cfg(SZ_2K, 3'h5, 11'h0ff);
    ahb(1'b1, TXD_OFF, 32'ha5, d);
    op(OP_START);
    op(OP_DEV);
    nk("dev word ack", 1'b0);
    op(OP_WADDR);
    nk("word address ack", 1'b0);
    op(OP_WRITE);
    nk("data ack", 1'b0);
    op(OP_STOP);
    chk("bus free", 32'h1, {31'h0, scl & sda_w});
    chk("stored byte", 32'ha5, {24'h0, MEM.mem[8'hff]});
    // Polling, random read, sequential wrap, recovery
    poll(1'b0);
    chk("write polls", 32'h2, tries);
    op(OP_WADDR);
    op(OP_START);
    op(OP_DEV, 1'b1);
    op(OP_READ, 1'b0, 1'b1);
    chk("random read", 32'ha5, {24'h0, st[15:8]});
    nk("host ack", 1'b0);
    op(OP_READ, 1'b0, 1'b1);
    chk("wrapped read", 32'h7e, {24'h0, st[15:8]});
    op(OP_RECOV);
    chk("recovery", 32'h1, {31'h0, st[STAT_FOUND]});
    op(OP_STOP);
    // Page write wrapping inside its page
    cfg(SZ_2K, 3'h5, 11'h01e);
    op(OP_START);
    op(OP_DEV);
    op(OP_WADDR);
    foreach (pg[i]) begin
      wp <= (i == 3);
      ahb(1'b1, TXD_OFF, {24'h0, pg[i]}, d);
      op(OP_WRITE);
      nk("page byte ack", 1'b0);
    end
    wp <= 1'b0;
    op(OP_STOP);
    chk("page first", 32'h11, {24'h0, MEM.mem[8'h1e]});
    chk("page second", 32'h22, {24'h0, MEM.mem[8'h1f]});
    chk("page wrapped", 32'h33, {24'h0, MEM.mem[8'h18]});
    chk("page untouched", 32'h97, {24'h0, MEM.mem[8'h19]});
    // Current address read after polling; page bits stand in for select bits
    cfg(SZ_16K, 3'h0, 11'h500);
    poll(1'b1);
    chk("read polls", 32'h2, tries);
    op(OP_READ);
    chk("current read", 32'h97, {24'h0, st[15:8]});
    nk("final no ack", 1'b1);
    op(OP_STOP);
    // Wrong select pins
    cfg(SZ_2K, 3'h2, 11'h000);
    op(OP_START);
    op(OP_DEV);
    nk("no match silent", 1'b1);
    op(OP_STOP);
    summarize();
  end
endmodule  // tb_eeh_host
